/* File: include/sci_pkg.sv */
// constants for the serial command packet intake
// assumes a byte-wide uart receiver/transmitter and a byte-wide nv store on core_clk
package sci_pkg;
  localparam int MAX_PKT_CHARS = 1000;
  localparam int CNT_W = 10;
  localparam int NSET = 16;
  localparam int IDX_W = 4;
  localparam logic [7:0] TERM_CHAR = 8'h0d;
  localparam logic [7:0] NULL_CHAR = 8'h00;
  localparam logic [7:0] ACK_CHAR = 8'h06;
  localparam logic [7:0] SAVE_CH0 = 8'h5a;
  localparam logic [7:0] SAVE_CH1 = 8'h32;
  localparam logic [7:0] ERASE_VAL = 8'hff;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam int WEAR_W = 17;
  localparam logic [16:0] WEAR_LIMIT = 17'h1_86a0;
  localparam logic [1:0] HS_NONE = 2'h0;
  localparam logic [1:0] HS_BUSY_READY = 2'h1;
  localparam logic [1:0] HS_MODEM = 2'h2;
  localparam logic RTS_BUSY_LVL = 1'b1;
endpackage

/* File: rtl/sci_intake.sv */
// serial command packet intake: parses two-byte commands, applies them to
// active settings, saves to / loads from nv store, paces the host.
// assumes rx/tx byte handshakes and nv store run on core_clk.
`timescale 1ns/1ns
module sci_intake #(
  parameter int NSET = sci_pkg::NSET,
  parameter int MAX_CHARS = sci_pkg::MAX_PKT_CHARS,
  parameter logic [16:0] WEAR_LIMIT = sci_pkg::WEAR_LIMIT
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [1:0] hs_mode,
  input wire logic ack_en,
  output logic rts_out,
  input wire logic bc_valid,
  input wire logic [3:0] bc_idx,
  input wire logic [7:0] bc_val,
  output logic bc_ready,
  input wire logic fw_update,
  output logic nv_req,
  output logic nv_we,
  output logic [3:0] nv_addr,
  output logic [7:0] nv_wdata,
  input wire logic [7:0] nv_rdata,
  input wire logic nv_ack,
  input wire logic [3:0] cfg_idx,
  output logic [7:0] cfg_data,
  output logic load_done,
  output logic nv_worn
);
  typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_EXEC, ST_NVWR, ST_ERASE, ST_ACK} sci_state_t;

  sci_state_t state_q;
  logic [7:0] act_q [NSET];
  logic [3:0] ptr_q;
  logic [9:0] cnt_q;
  logic half_q;
  logic [7:0] cmd0_q;
  logic [7:0] cmd1_q;
  logic fw_pend_q;
  logic [16:0] wear_q;
  logic load_done_q;
  logic [7:0] cfg_data_q;
  logic [7:0] tx_data_q;

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire idle = (state_q == ST_IDLE);
  wire rx_take = rx_valid && rx_ready;
  wire bc_take = bc_valid && bc_ready;
  wire is_term = (rx_data == sci_pkg::TERM_CHAR);
  wire lead_null = (rx_data == sci_pkg::NULL_CHAR) && (cnt_q == '0);
  wire room = (cnt_q < 10'(MAX_CHARS));
  wire is_save = (cmd0_q == sci_pkg::SAVE_CH0) && (cmd1_q == sci_pkg::SAVE_CH1);
  wire nv_walk = (state_q == ST_LOAD) || (state_q == ST_NVWR) || (state_q == ST_ERASE);
  wire walk_last = nv_ack && (ptr_q == 4'(NSET - 1));
  wire after_cmd_ack = ack_en;

  assign rx_ready = idle && !bc_valid && !fw_pend_q;
  assign bc_ready = idle && !fw_pend_q;
  assign rts_out = (hs_mode != sci_pkg::HS_NONE && !idle) ? sci_pkg::RTS_BUSY_LVL : !sci_pkg::RTS_BUSY_LVL;
  assign tx_valid = (state_q == ST_ACK);
  assign tx_data = tx_data_q;
  assign nv_req = nv_walk;
  assign nv_we = (state_q == ST_NVWR) || (state_q == ST_ERASE);
  assign nv_addr = ptr_q;
  assign nv_wdata = (state_q == ST_ERASE) ? sci_pkg::ERASE_VAL : act_q[ptr_q];
  assign cfg_data = cfg_data_q;
  assign load_done = load_done_q;
  assign nv_worn = (wear_q >= WEAR_LIMIT);

  ////////////////////////////////////////////////////////////////////////
  // control
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_LOAD;
      ptr_q <= '0;
      load_done_q <= 1'b0;
      tx_data_q <= sci_pkg::RESET_VAL;
    end else begin
      unique case (state_q)
        ST_LOAD: begin
          if (nv_ack) begin
            ptr_q <= ptr_q + 4'h1;
          end
          if (walk_last) begin
            state_q <= ST_IDLE;
            load_done_q <= 1'b1;
          end
        end
        ST_IDLE: begin
          ptr_q <= '0;
          if (fw_pend_q) begin
            state_q <= ST_ERASE;
          end else if (bc_take) begin
            state_q <= ST_NVWR;
          end else if (rx_take && !is_term && !lead_null && room && half_q) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (is_save) begin
            state_q <= ST_NVWR;
          end else begin
            state_q <= after_cmd_ack ? ST_ACK : ST_IDLE;
          end
          tx_data_q <= sci_pkg::ACK_CHAR;
        end
        ST_NVWR, ST_ERASE: begin
          if (nv_ack) begin
            ptr_q <= ptr_q + 4'h1;
          end
          if (walk_last) begin
            state_q <= (after_cmd_ack && state_q == ST_NVWR) ? ST_ACK : ST_IDLE;
          end
          tx_data_q <= sci_pkg::ACK_CHAR;
        end
        ST_ACK: begin
          if (tx_ready) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // character counting and command assembly
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      half_q <= 1'b0;
      cmd0_q <= sci_pkg::RESET_VAL;
      cmd1_q <= sci_pkg::RESET_VAL;
    end else if (rx_take) begin
      if (is_term) begin
        cnt_q <= '0;
        half_q <= 1'b0;
      end else if (!lead_null && room) begin
        cnt_q <= cnt_q + 10'h001;
        half_q <= !half_q;
        if (half_q) begin
          cmd1_q <= rx_data;
        end else begin
          cmd0_q <= rx_data;
        end
      end
    end
  end

  // firmware update request; a new request wins over the clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fw_pend_q <= 1'b0;
    end else begin
      fw_pend_q <= fw_update || (fw_pend_q && !idle);
    end
  end

  // save counter for nv wear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wear_q <= '0;
    end else if (state_q == ST_NVWR && walk_last && !nv_worn) begin
      wear_q <= wear_q + 17'h0_0001;
    end
  end

  // active settings, volatile only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NSET; i++) begin
        act_q[i] <= sci_pkg::RESET_VAL;
      end
      cfg_data_q <= sci_pkg::RESET_VAL;
    end else begin
      cfg_data_q <= act_q[cfg_idx];
      if (state_q == ST_LOAD && nv_ack) begin
        act_q[ptr_q] <= nv_rdata;
      end else if (state_q == ST_EXEC && !is_save) begin
        act_q[cmd0_q[3:0]] <= cmd1_q;
      end else if (bc_take && !fw_pend_q) begin
        act_q[bc_idx] <= bc_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_rx_held_busy: assert property (@(posedge core_clk) disable iff (!arst_n)
    !idle |-> !rx_ready) else $error("command taken while busy");

  a_rts_busy_exec: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_q == ST_EXEC && hs_mode != sci_pkg::HS_NONE) |-> rts_out == sci_pkg::RTS_BUSY_LVL)
    else $error("rts not busy during execution");

  a_ack_after_cmd: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_q == ST_EXEC && !is_save && ack_en) |=> tx_valid && tx_data == sci_pkg::ACK_CHAR)
    else $error("no ack after command");

  a_nv_write_save: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(nv_we) |-> $past(state_q == ST_EXEC && is_save) || $past(bc_take) || $past(fw_pend_q && idle))
    else $error("nv written outside save");

  a_save_walk: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_q == ST_EXEC && is_save) |=> state_q == ST_NVWR && ptr_q == 4'h0 && nv_we)
    else $error("save command did not start nv write");

  a_bc_saves: assert property (@(posedge core_clk) disable iff (!arst_n)
    (bc_take && !fw_pend_q) |=> state_q == ST_NVWR && act_q[$past(bc_idx)] == $past(bc_val))
    else $error("barcode setting not saved");

  a_erase_data: assert property (@(posedge core_clk) disable iff (!arst_n)
    (fw_pend_q && idle) |=> nv_we && nv_wdata == sci_pkg::ERASE_VAL)
    else $error("firmware update did not erase");

  a_load_first: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_q == ST_LOAD) |-> !load_done && !rx_ready && !nv_we) else $error("active used before load");

  a_len_cap: assert property (@(posedge core_clk) disable iff (!arst_n)
    cnt_q <= 10'(MAX_CHARS)) else $error("packet count beyond limit");

  a_drop_over: assert property (@(posedge core_clk) disable iff (!arst_n)
    (rx_take && !room && !is_term) |=> $stable(cmd0_q) && $stable(cmd1_q) && idle)
    else $error("over-length character used");
endmodule

/* File: dv/sci_nv_model.sv */
// behavioural nv word store answering the intake's nv port
// assumes one request at a time, held until nv_ack; contents survive reset
`timescale 1ns/1ns
module sci_nv_model #(
  parameter int LAT = 2
) (
  input wire logic core_clk,
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [3:0] nv_addr,
  input wire logic [7:0] nv_wdata,
  output logic [7:0] nv_rdata,
  output logic nv_ack
);
  logic [7:0] mem [16];
  int cnt;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'h10 + 8'(i);
    nv_ack = 1'b0;
    nv_rdata = 8'h00;
    cnt = 0;
  end
  // read data only means something with the ack pulse
  always @(posedge core_clk) begin
    nv_ack <= 1'b0;
    nv_rdata <= ~nv_rdata;
    if (nv_req && !nv_ack) begin
      cnt <= cnt + 1;
      if (cnt >= LAT) begin
        cnt <= 0;
        nv_ack <= 1'b1;
        if (nv_we) mem[nv_addr] <= nv_wdata;
        else nv_rdata <= mem[nv_addr];
      end
    end
  end
endmodule

/* File: dv/tb.sv */
// self-checking bench for the serial command intake
// assumes the host side is driven here and nv answers from sci_nv_model
`timescale 1ns/1ns
module tb;
  logic core_clk = 0, arst_n = 0, rx_valid = 0, tx_ready = 0, ack_en = 0, bc_valid = 0, fw_update = 0;
  logic [7:0] rx_data = 8'h00, bc_val = 8'h00, tx_data, cfg_data, nv_wdata, nv_rdata;
  logic [1:0] hs_mode = 2'h0;
  logic [3:0] bc_idx = 4'h0, cfg_idx = 4'h0, nv_addr;
  logic rx_ready, tx_valid, rts_out, bc_ready, nv_req, nv_we, nv_ack, load_done, nv_worn;
  int miscompares = 0, comparisons = 0;
  typedef struct {logic [3:0] idx; logic [7:0] val; logic [1:0] hs; logic ack;} sci_row_t;
  sci_row_t rows [4] = '{'{4'h2, 8'h21, 2'h0, 1'b1}, '{4'h3, 8'h41, 2'h1, 1'b0},
                         '{4'h7, 8'h7e, 2'h2, 1'b1}, '{4'hf, 8'hc3, 2'h1, 1'b0}};
  sci_intake u_sci_intake (.core_clk(core_clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .hs_mode(hs_mode),
    .ack_en(ack_en), .rts_out(rts_out), .bc_valid(bc_valid), .bc_idx(bc_idx), .bc_val(bc_val),
    .bc_ready(bc_ready), .fw_update(fw_update), .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .nv_ack(nv_ack), .cfg_idx(cfg_idx), .cfg_data(cfg_data),
    .load_done(load_done), .nv_worn(nv_worn));
  sci_nv_model u_sci_nv_model (.core_clk(core_clk), .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_rdata(nv_rdata), .nv_ack(nv_ack));
  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out();
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task send(input logic [7:0] b);
    int n;
    @(posedge core_clk) #1;
    rx_valid = 1'b1;
    rx_data = b;
    for (n = 0; n < 400 && !rx_ready; n++) @(posedge core_clk) #1;
    chk("rx_ready", rx_ready, 1'b1);
    @(posedge core_clk) #1;
    rx_valid = 1'b0;
  endtask
  // wait out execution, take any ack only after the first four cycles of the wait
  task fin(input logic exp_ack);
    int n;
    logic acked;
    acked = 1'b0;
    for (n = 0; n < 400 && (n < 2 || !rx_ready); n++) begin
      if (!rx_ready) chk("rts_out", rts_out, hs_mode != 2'h0);
      if (tx_valid && n > 3) begin
        chk("rx_ready", rx_ready, 1'b0);
        chk("tx_data", tx_data, sci_pkg::ACK_CHAR);
        tx_ready = 1'b1;
        acked = 1'b1;
      end
      @(posedge core_clk) #1;
      tx_ready = 1'b0;
    end
    chk("rx_ready", rx_ready, 1'b1);
    chk("ack", acked, exp_ack);
  endtask
  task cmd(input logic [3:0] i, input logic [7:0] v);
    // no nulls ahead of a command, so no settle wait
    send({4'h0, i});
    send(v);
    fin(ack_en);
  endtask
  task cfg(input logic [3:0] i, input logic [7:0] v);
    cfg_idx = i;
    repeat (2) @(posedge core_clk) #1;
    chk("cfg_data", cfg_data, v);
  endtask
  task rst();
    int n;
    arst_n = 1'b0;
    repeat (4) @(posedge core_clk) #1;
    chk("nv_we", nv_we, 1'b0);
    chk("load_done", load_done, 1'b0);
    arst_n = 1'b1;
    for (n = 0; n < 400 && !load_done; n++) @(posedge core_clk) #1;
    chk("load_done", load_done, 1'b1);
    @(posedge core_clk) #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 20000);
    miscompares++;
    close_out();
  end
  initial begin
    rst();
    cfg(4'h9, 8'h19);
    foreach (rows[k]) begin
      hs_mode = rows[k].hs;
      ack_en = rows[k].ack;
      cmd(rows[k].idx, rows[k].val);
      cfg(rows[k].idx, rows[k].val);
    end
    send(sci_pkg::SAVE_CH0);
    send(sci_pkg::SAVE_CH1);
    fin(ack_en);
    foreach (rows[k]) chk("nv", u_sci_nv_model.mem[rows[k].idx], rows[k].val);
    send(sci_pkg::TERM_CHAR);
    cmd(4'h2, 8'haa);
    rst();
    cfg(4'h2, 8'h21);
    ack_en = 1'b1;
    cmd(4'h2, 8'h3c);
    bc_valid = 1'b1;
    bc_idx = 4'h9;
    bc_val = 8'h5c;
    for (int n = 0; n < 400 && !bc_ready; n++) @(posedge core_clk) #1;
    chk("bc_ready", bc_ready, 1'b1);
    @(posedge core_clk) #1;
    bc_valid = 1'b0;
    fin(1'b1);
    chk("nv_bc", u_sci_nv_model.mem[9], 8'h5c);
    chk("nv_prev", u_sci_nv_model.mem[2], 8'h3c);
    send(sci_pkg::TERM_CHAR);
    ack_en = 1'b0;
    repeat (500) cmd(4'h5, 8'h77);
    send(8'h05);
    send(8'h99);
    repeat (4) @(posedge core_clk) #1;
    cfg(4'h5, 8'h77);
    send(sci_pkg::TERM_CHAR);
    cmd(4'h5, 8'h88);
    cfg(4'h5, 8'h88);
    fw_update = 1'b1;
    @(posedge core_clk) #1;
    fw_update = 1'b0;
    @(posedge core_clk) #1;
    fin(1'b0);
    for (int i = 0; i < 16; i++) chk("erase", u_sci_nv_model.mem[i], sci_pkg::ERASE_VAL);
    chk("nv_worn", nv_worn, 1'b0);
    close_out();
  end
endmodule
